/* File: common/bldc_cfg.svh */
// Constants of the burst laser driver control block: offsets, fields, timing
`ifndef BLDC_CFG_SVH
`define BLDC_CFG_SVH

// Clock rate of pclk
`define BLDC_PCLK_MHZ 50

// Stuck link clock: time without an edge before alarm
`define BLDC_CLK_LOSS_NS 100
`define BLDC_CLK_LOSS_CYC ((`BLDC_CLK_LOSS_NS * `BLDC_PCLK_MHZ) / 1000)

// Temperature detection period
`define BLDC_CONV_PERIOD_MS 128
`define BLDC_CONV_CYC (`BLDC_CONV_PERIOD_MS * `BLDC_PCLK_MHZ * 1000)

// Register byte addresses
`define BLDC_CONFIG_ADDR 12'h000
`define BLDC_STATUS_ADDR 12'h004
`define BLDC_DACS_ADDR 12'h008
// Current tables: byte address = base + 4 * index, index 00h..FFh
`define BLDC_TABLE_SEL 2'h1
// Duty table: byte address = base + 4 * index, index 00h..1Fh
`define BLDC_DUTY_SEL 5'h10
// Start of the bias half of the current table
`define BLDC_BIAS_TABLE_OFS 8'h80

// CONFIG fields
`define BLDC_CFG_CLKPOL_BIT 0
`define BLDC_CFG_ACTPOL_BIT 1
`define BLDC_CFG_DISPOL_BIT 2
`define BLDC_CFG_THR_LSB 4

// STATUS fields
`define BLDC_ST_CLOCK_LOSS_ALARM_BIT 0
`define BLDC_ST_ACTDET_BIT 1
`define BLDC_ST_SHUTDN_BIT 2
`define BLDC_ST_BIAS_BIT 3
`define BLDC_ST_TEMP_LSB 8

// DACS fields
`define BLDC_DACS_BIAS_LSB 8
`define BLDC_DACS_DUTY_LSB 16

// Bias code clamp
`define BLDC_BIAS_MIN_CODE 8'h05

// Reset values
`define BLDC_CFG_RESET 7'h00
`define BLDC_TABLE_RESET 8'h00

`endif

/* File: common/bldc_pkg.sv */
// Types shared by the burst laser driver control block
package bldc_pkg;

  // Codes presented to the current DACs and the duty extender
  typedef struct packed {
    logic [7:0] mod_code;   // Modulation DAC code
    logic [7:0] bias_code;  // Bias DAC code after clamp
    logic [4:0] duty_code;  // Pulse extension code
    logic dac_hiz;          // Both DAC outputs high impedance
    logic bias_hiz;         // Bias driver off, output high impedance
  } bldc_dac_t;

  // Whole state of the block
  typedef struct packed {
    logic lclk_s1;
    logic lclk_s2;
    logic lclk_d;
    logic burst_s1;
    logic burst_s2;
    logic data_s1;
    logic data_s2;
    logic sel_s1;
    logic sel_s2;
    logic dis_s1;
    logic dis_s2;
    logic cmp_s1;
    logic cmp_s2;
    logic [6:0] temp_s1;
    logic [6:0] temp_s2;
    logic burst_q;
    logic data_q;
    logic last_data;
    logic bias_on;
    logic mod_data;
    logic [3:0] stuck_cnt;
    logic clk_alarm;
    logic act_det;
    logic shutdown;
    logic [22:0] conv_cnt;
    logic [6:0] temp_code;
    logic load_pend;
    logic clk_pol;
    logic act_pol;
    logic dis_pol;
    logic [2:0] thr;
    logic [255:0][7:0] tbl;
    logic [31:0][4:0] duty_tbl;
    bldc_dac_t dac;
    logic clk_alarm_pin;
    logic act_pin;
    logic [3:0] ref_tenths;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } bldc_state_t;

endpackage

/* File: src/bldc_top.sv */
// Burst laser driver control: input capture, feed-forward lookup, alarms
`timescale 1ns/10ps
`include "bldc_cfg.svh"

//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Latched mode samples burst, data on falling clock
// - Bias switches on soon after sampled burst
// - Direct mode needs no clock; data delayed
// - Duty code from 6 degree temperature table
// - Duty code five bits, 0.03ns per step
// - Temperature converted to 7 bits every 128ms
// - Conversion loads mod and bias DAC codes
// - Bias code 0 off, 1-4 become 5
// - Mod and bias tables hold one entry per temperature code
// - Threshold code selects 0.9V down to 0.2V
// - Active alarm output polarity selectable
// - In latched mode, clock stuck over 100ns raises clock alarm
// - Clock alarm output polarity selectable
// - Shutdown on disable request or clock alarm
// - Disable input polarity selectable
// - Shutdown: DACs high-Z, data 0, bias off
// - Data drives modulation; zero without burst
// - Bias on during burst; extended after data 1
// - Mod table 00h-7Fh, bias table 80h-FFh
// - Duty table indexed by top five bits
module bldc_top #(
  parameter int unsigned CONV_CYCLES = `BLDC_CONV_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_clock,
  input wire logic latch_select,
  input wire logic burst_enable,
  input wire logic data_in,
  input wire logic transmit_disable,
  input wire logic [6:0] junction_temp_sensor,
  input wire logic monitor_photodiode_input,
  output logic mod_data,
  output logic bias_enable,
  output bldc_pkg::bldc_dac_t dac_out,
  output logic [3:0] active_ref_tenths,
  output logic active_alarm,
  output logic clock_loss_alarm
);
  import bldc_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // State and helpers

  bldc_state_t s;       // Registered state
  bldc_state_t next_s;  // Next state

  // Reference level in tenths of a volt for a threshold code
  function automatic logic [3:0] ref_of(input logic [2:0] code);
    logic [3:0] r;
    r = 4'h6;
    case (code)
      3'h3: r = 4'h9;
      3'h2: r = 4'h8;
      3'h1: r = 4'h7;
      3'h0: r = 4'h6;
      3'h4: r = 4'h5;
      3'h5: r = 4'h4;
      3'h6: r = 4'h3;
      3'h7: r = 4'h2;
      default: r = 4'h6;
    endcase
    return r;
  endfunction

  // Stored bias code to DAC code: zero stays zero (driver off)
  function automatic logic [7:0] bias_map(input logic [7:0] code);
    logic [7:0] r;
    r = code;
    if (code != 8'h00 && code < `BLDC_BIAS_MIN_CODE)
    begin
      r = `BLDC_BIAS_MIN_CODE;
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb
  begin
    logic lclk_fall;     // Falling edge of the synced link clock
    logic lclk_edge;     // Any edge of the synced link clock
    logic dis_req;       // Disable request after polarity
    logic sd;            // Shutdown condition
    logic burst_eff;     // Burst after shutdown gating
    logic setup;         // APB setup cycle
    logic access;        // APB access completes this edge
    logic hit;           // Address maps to a register
    logic ro;            // Address is read only
    logic [31:0] rd;     // Read data for the decoded address
    logic [7:0] tidx;    // Current table index
    logic [4:0] didx;    // Duty table index
    logic [4:0] dsel;    // Duty index from temperature
    lclk_fall = 1'b0;
    lclk_edge = 1'b0;
    dis_req = 1'b0;
    sd = 1'b0;
    burst_eff = 1'b0;
    setup = 1'b0;
    access = 1'b0;
    hit = 1'b0;
    ro = 1'b0;
    rd = 32'h0000_0000;
    tidx = 8'h00;
    didx = 5'h00;
    dsel = 5'h00;
    next_s = s;

    // Two-stage synchronisers; only stage two is read by logic
    next_s.lclk_s1 = link_clock;
    next_s.lclk_s2 = s.lclk_s1;
    next_s.lclk_d = s.lclk_s2;
    next_s.burst_s1 = burst_enable;
    next_s.burst_s2 = s.burst_s1;
    next_s.data_s1 = data_in;
    next_s.data_s2 = s.data_s1;
    next_s.sel_s1 = latch_select;
    next_s.sel_s2 = s.sel_s1;
    next_s.dis_s1 = transmit_disable;
    next_s.dis_s2 = s.dis_s1;
    next_s.cmp_s1 = monitor_photodiode_input;
    next_s.cmp_s2 = s.cmp_s1;
    // Sensor code is assumed to settle long before the conversion tick
    next_s.temp_s1 = junction_temp_sensor;
    next_s.temp_s2 = s.temp_s1;

    lclk_fall = s.lclk_d & ~s.lclk_s2;
    lclk_edge = s.lclk_d ^ s.lclk_s2;

    // Input capture: latched on falling clock, or taken directly
    if (s.sel_s2)
    begin
      if (lclk_fall)
      begin
        next_s.burst_q = s.burst_s2;
        next_s.data_q = s.data_s2;
      end
    end
    else
    begin
      // Direct mode: no clock involved at all
      next_s.burst_q = s.burst_s2;
      next_s.data_q = s.data_s2;
    end

    // Stuck clock watchdog, restarted on every edge
    if (!s.sel_s2)
    begin
      // Without a clock the alarm shows its non-detected level
      next_s.stuck_cnt = 4'h0;
      next_s.clk_alarm = 1'b0;
    end
    else if (lclk_edge)
    begin
      next_s.stuck_cnt = 4'h0;
      next_s.clk_alarm = 1'b0;
    end
    else if (s.stuck_cnt == 4'(`BLDC_CLK_LOSS_CYC))
    begin
      next_s.clk_alarm = 1'b1;
    end
    else
    begin
      next_s.stuck_cnt = s.stuck_cnt + 4'h1;
    end

    // Shutdown from the disable pin or the clock alarm
    dis_req = s.dis_s2 ^ s.dis_pol;
    sd = dis_req | s.clk_alarm;
    next_s.shutdown = sd;

    // Modulation data and bias switching
    burst_eff = s.burst_q & ~sd;
    next_s.mod_data = burst_eff & s.data_q;
    if (burst_eff)
    begin
      next_s.bias_on = 1'b1;
      next_s.last_data = s.data_q;
    end
    else if (s.bias_on && s.last_data && !sd
             && s.dac.duty_code != 5'h00)
    begin
      // One extra cycle protects a trailing one bit
      next_s.bias_on = 1'b1;
      next_s.last_data = 1'b0;
    end
    else
    begin
      next_s.bias_on = 1'b0;
      next_s.last_data = 1'b0;
    end

    // Active alarm latch, released when the burst ends or on shutdown
    if (!s.burst_q || sd)
    begin
      next_s.act_det = 1'b0;
    end
    else if (s.cmp_s2)
    begin
      next_s.act_det = 1'b1;
    end

    // Alarm pins with selectable polarity
    next_s.act_pin = next_s.act_det ^ s.act_pol;
    next_s.clk_alarm_pin = next_s.clk_alarm ^ s.clk_pol;
    next_s.ref_tenths = ref_of(s.thr);

    // Periodic temperature conversion
    if (s.conv_cnt == 23'(CONV_CYCLES - 1))
    begin
      next_s.conv_cnt = 23'h0;
      next_s.temp_code = s.temp_s2;
      next_s.load_pend = 1'b1;
    end
    else
    begin
      next_s.conv_cnt = s.conv_cnt + 23'h1;
    end

    // Table lookup one cycle after the conversion; runs in shutdown too
    if (s.load_pend)
    begin
      next_s.load_pend = 1'b0;
      next_s.dac.mod_code = s.tbl[{1'b0, s.temp_code}];
      next_s.dac.bias_code =
        bias_map(s.tbl[{1'b1, s.temp_code}]);
      next_s.dac.bias_hiz =
        (s.tbl[{1'b1, s.temp_code}] == 8'h00);
      dsel = s.temp_code[6:2];
      next_s.dac.duty_code = s.duty_tbl[dsel];
    end
    next_s.dac.dac_hiz = sd;

    //////////////////////////////////////////////////////////////////////
    // APB slave: decode in setup, answer in a single access cycle
    setup = psel & ~penable;
    access = psel & penable & s.pready;
    tidx = paddr[9:2];
    didx = paddr[6:2];
    if (paddr[1:0] != 2'h0)
    begin
      hit = 1'b0;
    end
    else if (paddr == `BLDC_CONFIG_ADDR)
    begin
      hit = 1'b1;
      rd[`BLDC_CFG_CLKPOL_BIT] = s.clk_pol;
      rd[`BLDC_CFG_ACTPOL_BIT] = s.act_pol;
      rd[`BLDC_CFG_DISPOL_BIT] = s.dis_pol;
      rd[`BLDC_CFG_THR_LSB +: 3] = s.thr;
    end
    else if (paddr == `BLDC_STATUS_ADDR)
    begin
      hit = 1'b1;
      ro = 1'b1;
      rd[`BLDC_ST_CLOCK_LOSS_ALARM_BIT] = s.clk_alarm;
      rd[`BLDC_ST_ACTDET_BIT] = s.act_det;
      rd[`BLDC_ST_SHUTDN_BIT] = s.shutdown;
      rd[`BLDC_ST_BIAS_BIT] = s.bias_on;
      rd[`BLDC_ST_TEMP_LSB +: 7] = s.temp_code;
    end
    else if (paddr == `BLDC_DACS_ADDR)
    begin
      hit = 1'b1;
      ro = 1'b1;
      rd[7:0] = s.dac.mod_code;
      rd[`BLDC_DACS_BIAS_LSB +: 8] = s.dac.bias_code;
      rd[`BLDC_DACS_DUTY_LSB +: 5] = s.dac.duty_code;
    end
    else if (paddr[11:10] == `BLDC_TABLE_SEL)
    begin
      hit = 1'b1;
      rd[7:0] = s.tbl[tidx];
    end
    else if (paddr[11:7] == `BLDC_DUTY_SEL)
    begin
      hit = 1'b1;
      rd[4:0] = s.duty_tbl[didx];
    end

    // Answer registered in setup so it stands through the access cycle
    next_s.pready = setup;
    if (setup)
    begin
      next_s.prdata = pwrite ? 32'h0000_0000 : rd;
      next_s.pslverr = ~hit | (pwrite & ro);
    end
    else
    begin
      next_s.prdata = 32'h0000_0000;
      next_s.pslverr = 1'b0;
    end

    // Writes take effect only at the completing edge
    if (access && pwrite && !s.pslverr)
    begin
      if (paddr == `BLDC_CONFIG_ADDR)
      begin
        next_s.clk_pol = pwdata[`BLDC_CFG_CLKPOL_BIT];
        next_s.act_pol = pwdata[`BLDC_CFG_ACTPOL_BIT];
        next_s.dis_pol = pwdata[`BLDC_CFG_DISPOL_BIT];
        next_s.thr = pwdata[`BLDC_CFG_THR_LSB +: 3];
      end
      else if (paddr[11:10] == `BLDC_TABLE_SEL)
      begin
        next_s.tbl[tidx] = pwdata[7:0];
      end
      else if (paddr[11:7] == `BLDC_DUTY_SEL)
      begin
        next_s.duty_tbl[didx] = pwdata[4:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // State register; all outputs come from here

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
      // Shutdown with high-impedance DACs until the first clock edges
      s.dac.dac_hiz <= 1'b1;
      s.dac.bias_hiz <= 1'b1;
      s.ref_tenths <= 4'h6;
    end
    else
    begin
      s <= next_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign mod_data = s.mod_data;
  assign bias_enable = s.bias_on;
  assign dac_out = s.dac;
  assign active_ref_tenths = s.ref_tenths;
  assign active_alarm = s.act_pin;
  assign clock_loss_alarm = s.clk_alarm_pin;

endmodule

/* File: verif/bldc_top_monitor.sv */
// Port checker for the burst laser driver control block
`timescale 1ns/10ps
module bldc_top_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic link_clock,
  input wire logic latch_select,
  input wire logic burst_enable,
  input wire logic mod_data,
  input wire logic bias_enable,
  input wire bldc_pkg::bldc_dac_t dac_out,
  input wire logic [3:0] active_ref_tenths
);
  import bldc_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Cycles since the last link clock edge, latched mode only
  logic [3:0] stk;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      stk <= 4'h0;
    else if (!latch_select || $changed(link_clock))
      stk <= 4'h0;
    else if (stk != 4'hF)
      stk <= stk + 4'h1;
  // 12 cycles is 240 ns, past the 200 ns worst case
  property p_stk;
    stk == 4'hC |-> dac_out.dac_hiz;
  endproperty
  a_stk: assert property (p_stk) else $error("stuck clock ignored");
  property p_lat;
    (latch_select && burst_enable && !dac_out.dac_hiz)[*8] |-> ##[0:4]
      bias_enable;
  endproperty
  a_lat: assert property (p_lat) else $error("latched bias late");
  property p_dir;
    (!latch_select && burst_enable && !dac_out.dac_hiz)[*5] |-> bias_enable;
  endproperty
  a_dir: assert property (p_dir) else $error("direct bias late");
  property p_off;
    (!latch_select && !burst_enable)[*6] |-> !bias_enable && !mod_data;
  endproperty
  a_off: assert property (p_off) else $error("drive without burst");
  property p_mod;
    mod_data |-> bias_enable;
  endproperty
  a_mod: assert property (p_mod) else $error("data without bias");
  property p_sd;
    dac_out.dac_hiz && $past(dac_out.dac_hiz) |-> !mod_data && !bias_enable;
  endproperty
  a_sd: assert property (p_sd) else $error("drive in shutdown");
  property p_clamp;
    !dac_out.bias_hiz |-> dac_out.bias_code >= 8'h05;
  endproperty
  a_clamp: assert property (p_clamp) else $error("bias below 5");
  property p_zero;
    dac_out.bias_hiz |-> dac_out.bias_code == 8'h00;
  endproperty
  a_zero: assert property (p_zero) else $error("bias off, code set");
  property p_ref;
    active_ref_tenths inside {[4'h2:4'h9]};
  endproperty
  a_ref: assert property (p_ref) else $error("reference out of range");
  // Zero wait slave: ready follows every setup cycle
  property p_rdy;
    psel && !penable |=> pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
endmodule
bind bldc_top bldc_top_monitor u_mon (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pready(pready),
  .link_clock(link_clock),
  .latch_select(latch_select),
  .burst_enable(burst_enable),
  .mod_data(mod_data),
  .bias_enable(bias_enable),
  .dac_out(dac_out),
  .active_ref_tenths(active_ref_tenths)
);

/* File: verif/bldc_framer_model.sv */
// Upstream framer model: link clock, burst enable and serial data
`timescale 1ns/10ps
module bldc_framer_model (
  input wire logic pclk,
  output logic link_clock,
  output logic burst_enable,
  output logic data_in
);
  logic run = 1'b0; // Clock stands still between frames
  logic [2:0] ph = 3'h0; // Phase in a 160 ns link period
  initial
  begin
    link_clock = 1'b0;
    burst_enable = 1'b0;
    data_in = 1'b0;
  end
  // Link clock from pclk, restarted in phase each frame
  always @(posedge pclk)
  begin
    ph <= run ? ph + 3'h1 : 3'h0;
    link_clock <= run ? ph[2] : link_clock;
  end
  // One frame of eight bits, msb first, mid-bit sampling
  task automatic send(input logic [7:0] pat, input logic clk_on);
    run <= clk_on;
    repeat (16) @(posedge pclk);
    burst_enable <= 1'b1;
    repeat (20) @(posedge pclk); // Data after two and a half periods
    for (int i = 7; i >= 0; i--)
    begin
      data_in <= pat[i];
      repeat (8) @(posedge pclk);
    end
    burst_enable <= 1'b0; // Only after the last bit
    repeat (4) @(posedge pclk);
    data_in <= ~pat[0]; // Released line shows inverse
    repeat (12) @(posedge pclk);
    run <= 1'b0;
  endtask
endmodule

/* File: verif/tb_bldc_top.sv */
// Self-checking bench for the burst laser driver control block
`timescale 1ns/10ps
module tb_bldc_top;
  import bldc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic latch_select = 1'b1;
  logic transmit_disable = 1'b0;
  logic [6:0] junction_temp_sensor = 7'h00;
  logic monitor_photodiode_input = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, link_clock, burst_enable, data_in;
  logic mod_data, bias_enable, active_alarm, clock_loss_alarm;
  logic [3:0] active_ref_tenths;
  bldc_dac_t dac_out;
  logic [31:0] rv;
  logic se;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  int mc = 0;
  int bc = 0;
  always #10 pclk = ~pclk;
  bldc_top #(.CONV_CYCLES(64)) dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .link_clock(link_clock),
    .latch_select(latch_select),
    .burst_enable(burst_enable),
    .data_in(data_in),
    .transmit_disable(transmit_disable),
    .junction_temp_sensor(junction_temp_sensor),
    .monitor_photodiode_input(monitor_photodiode_input),
    .mod_data(mod_data),
    .bias_enable(bias_enable),
    .dac_out(dac_out),
    .active_ref_tenths(active_ref_tenths),
    .active_alarm(active_alarm),
    .clock_loss_alarm(clock_loss_alarm)
  );
  // Upstream framer drives the link side
  bldc_framer_model fr (
    .pclk(pclk),
    .link_clock(link_clock),
    .burst_enable(burst_enable),
    .data_in(data_in)
  );
  // Drive-cycle counters and the hang limit
  always @(posedge pclk)
  begin
    mc <= mc + int'(mod_data === 1'b1);
    bc <= bc + int'(bias_enable === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data and error land in rv, se
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rv = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic t_regs();
    apb(0, 12'h000, 0);
    chk(rv, 0);
    apb(1, 12'h000, 32'h77);
    apb(0, 12'h000, 0);
    chk(rv, 32'h77);
    chk({clock_loss_alarm, active_alarm}, 2'b01);
    apb(1, 12'h000, 0);
    @(posedge pclk);
    chk(clock_loss_alarm, 1);
    apb(0, 12'h004, 0);
    chk(rv & 32'h5, 32'h5);
    apb(1, 12'h004, 32'hF);
    chk(se, 1);
    apb(0, 12'h0FC, 0);
    chk(rv, 32'h0);
    chk(se, 1'b1);
    $display("regs test done");
  endtask
  task automatic t_thr();
    logic [31:0] e [8] = '{6, 7, 8, 9, 5, 4, 3, 2};
    for (int i = 0; i < 8; i++)
    begin
      apb(1, 12'h000, 32'(i) << 4);
      @(posedge pclk);
      chk(active_ref_tenths, e[i]);
    end
    apb(1, 12'h000, 0);
    $display("threshold test done");
  endtask
  // Table lookup while shut down by the stopped link clock
  task automatic t_ff();
    logic [7:0] b [3] = '{8'h00, 8'h03, 8'h40};
    logic [7:0] e [3] = '{8'h00, 8'h05, 8'h40};
    junction_temp_sensor <= 7'h2D;
    for (int i = 0; i < 3; i++)
    begin
      apb(1, 12'h4B4, 32'hA5);
      apb(1, 12'h6B4, {24'h0, b[i]});
      apb(1, 12'h82C, 32'(31 - i));
      repeat (140) @(posedge pclk);
      apb(0, 12'h008, 0);
      chk(rv, {11'h0, 5'(31 - i), e[i], 8'hA5});
      chk({dac_out.dac_hiz, dac_out.bias_hiz}, {1'b1, i == 0});
      chk(dac_out, {8'hA5, e[i], 5'(31 - i), 1'b1, i == 0});
      apb(0, 12'h004, 0);
      chk(rv[14:8], 7'h2D);
      apb(0, 12'h6B4, 0);
      chk(rv, b[i]);
    end
    $display("feed-forward test done");
  endtask
  // One frame B1h with an early photodiode pulse
  task automatic t_burst(input logic m);
    int m0 = mc;
    latch_select <= m;
    fork
      fr.send(8'hB1, m);
      begin
        repeat (50) @(posedge pclk);
        monitor_photodiode_input <= 1'b1;
        repeat (8) @(posedge pclk);
        monitor_photodiode_input <= 1'b0;
        repeat (16) @(posedge pclk);
        chk(active_alarm, 1);
      end
    join
    chk(mc - m0, 32);
    chk({active_alarm, bias_enable, mod_data}, 0);
    $display("burst test done");
  endtask
  task automatic t_dis();
    int m0 = mc;
    int b0 = bc;
    transmit_disable <= 1'b1;
    monitor_photodiode_input <= 1'b1;
    fr.send(8'hFF, 1'b0);
    chk(mc - m0, 0);
    chk(bc - b0, 0);
    chk({dac_out.dac_hiz, active_alarm, clock_loss_alarm}, 3'b100);
    apb(1, 12'h000, 32'h4);
    @(posedge pclk);
    chk(dac_out.dac_hiz, 0);
    transmit_disable <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(dac_out.dac_hiz, 1);
    $display("disable test done");
  endtask
  task automatic final_report();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_thr();
    t_ff();
    t_burst(1'b1);
    t_burst(1'b0);
    t_dis();
    final_report();
  end
endmodule
